// File: shared/reset_pkg.sv
/*
 * Constants, register map and types of the reset source combiner.
 * Assumes a single 20 MHz bus clock; all delays but the start-up timer, which counts oscillator edges, are counted in its cycles.
 */
package reset_pkg;

    // clock
    localparam int CLK_PERIOD_NS   = 50;

    // times as specified, in ns
    localparam int POR_EXT_NS      = 30000;
    localparam int BOR_EXT_NS      = 100000;
    localparam int FRC_OSCD_NS     = 1100;
    localparam int LOW_POWER_RC_OSCILLATOR_OSCD_NS    = 70000;
    localparam int LOCK_NS         = 1500000;
    localparam int FSCM_NS         = 900000;
    localparam int PWRT_UNIT_NS    = 1000000;

    // derived cycle counts; all times round down
    localparam int POR_EXT_CYC     = POR_EXT_NS / CLK_PERIOD_NS;
    localparam int BOR_EXT_CYC     = BOR_EXT_NS / CLK_PERIOD_NS;
    localparam int FRC_OSCD_CYC    = FRC_OSCD_NS / CLK_PERIOD_NS;
    localparam int LOW_POWER_RC_OSCILLATOR_OSCD_CYC   = LOW_POWER_RC_OSCILLATOR_OSCD_NS / CLK_PERIOD_NS;
    localparam int LOCK_CYC        = LOCK_NS / CLK_PERIOD_NS;
    localparam int FSCM_CYC        = FSCM_NS / CLK_PERIOD_NS;
    localparam int PWRT_UNIT_CYC   = PWRT_UNIT_NS / CLK_PERIOD_NS;
    localparam int XTAL_OSCD_CYC   = 1000;
    localparam int OST_EDGES       = 1024;

    // register map, byte addresses
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  RESET_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  OSC_CTRL_OFS     = 8'h04;
    localparam logic [7:0]  OSC_CONFIG_OFS   = 8'h08;
    localparam logic [7:0]  POR_CONFIG_OFS   = 8'h0c;
    localparam logic [7:0]  SEQ_STATUS_OFS   = 8'h10;

    // reset status flag positions in reset_control_register
    localparam int FLAG_POR        = 0;
    localparam int FLAG_BOR        = 1;
    localparam int FLAG_PIN        = 2;
    localparam int FLAG_INSTR      = 3;
    localparam int FLAG_WDT        = 4;
    localparam int FLAG_CM         = 5;
    localparam int FLAG_TRAP       = 6;
    localparam int FLAG_ILLEGAL    = 7;
    localparam int NUM_FLAGS       = 8;

    // field positions
    localparam int CUR_CLK_LSB     = 12;
    localparam int CLK_FAIL_BIT    = 0;
    localparam int PLL_EN_BIT      = 3;
    localparam int STAT_MRST_BIT   = 4;
    localparam int STAT_COLD_BIT   = 5;

    // reset values
    localparam logic [7:0] FLAGS_RST       = 8'h01;
    localparam logic [2:0] BOOT_SEL_RST    = 3'h0;
    localparam logic [2:0] PWRT_SEL_RST    = 3'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        CLK_FAST_RC      = 3'h0,
        CLK_CRYSTAL      = 3'h1,
        CLK_HIGH_SPEED   = 3'h2,
        CLK_SECONDARY    = 3'h3,
        CLK_LOW_POWER_RC = 3'h4,
        CLK_EXTERNAL     = 3'h5
    } clock_mode_t;

    typedef enum logic [3:0] {
        ST_HOLD      = 4'h0,
        ST_EXTEND    = 4'h1,
        ST_SUPPLY    = 4'h2,
        ST_OSC_DELAY = 4'h3,
        ST_OST       = 4'h4,
        ST_LOCK      = 4'h5,
        ST_READY     = 4'h6,
        ST_RUN       = 4'h7
    } seq_state_t;

endpackage

// File: design/delay_timer.sv
/*
 * Loadable down counter used for the timed release stages (extension, oscillator delay, start-up timer, lock) of the reset sequencer.
 * Assumes load is a one-cycle pulse; tick gates each decrement.
 */
module delay_timer #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] length,
    input  wire logic         tick,
    // status
    output logic              expired,
    output logic [W-1:0]      remaining
);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remaining <= '0;
            expired   <= 1'b1;
        end else if (load) begin
            remaining <= length;
            expired   <= (length == '0);
        end else if (!expired && tick) begin
            remaining <= remaining - W'(1);
            expired   <= (remaining == W'(1));
        end
    end

endmodule

// File: design/reset_source_combiner.sv
/*
 * Reset source combiner: merges all reset sources into the master system
 * reset, records per-source status flags, sequences supply and oscillator
 * delays before release, and loads the boot clock source on cold reset only, keeping it on warm reset.
 * Assumes async source levels from supervisors and pins, a one-cycle
 * instruction reset pulse on aclk, and an AXI4-Lite master for the registers.
 */
module reset_source_combiner
    import reset_pkg::*;
#(
    parameter int LOCK_CYCLES      = LOCK_CYC,
    parameter int FSCM_CYCLES      = FSCM_CYC,
    parameter int PWRT_UNIT_CYCLES = PWRT_UNIT_CYC,
    parameter int XTAL_OSCD_CYCLES = XTAL_OSCD_CYC
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // reset sources
    input  wire logic              power_on_reset,
    input  wire logic              brown_out_reset,
    input  wire logic              external_pin_reset,
    input  wire logic              instruction_reset,
    input  wire logic              watchdog_timeout_reset,
    input  wire logic              config_mismatch_reset,
    input  wire logic              trap_conflict_reset,
    input  wire logic              illegal_condition_reset,
    // supply and oscillator status
    input  wire logic              supply_stable,
    input  wire logic              osc_ready,
    input  wire logic              osc_clock,
    // reset and clock outputs
    output logic                   master_system_reset,
    output logic [2:0]             clock_source,
    output logic                   pll_enable,
    output logic                   clock_fail,
    // axi4-lite write address
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [ADDR_W-1:0] awaddr,
    // axi4-lite write data
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    // axi4-lite write response
    output logic                   bvalid,
    input  wire logic              bready,
    output logic [1:0]             bresp,
    // axi4-lite read
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [ADDR_W-1:0] araddr,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp
);

    localparam int NSYNC = 10;

    logic [NSYNC-1:0]    sync1;
    logic [NSYNC-1:0]    sync2;
    logic [NSYNC-1:0]    sync3;
    logic [NSYNC-1:0]    filt;
    logic [NSYNC-1:0]    filt_prev;
    logic [NUM_FLAGS-1:0] ev;
    logic [NUM_FLAGS-1:0] reset_control_register;
    logic                src_any;
    logic                osc_edge;
    logic [2:0]          boot_clock_select;
    logic                boot_pll;
    logic [2:0]          power_up_delay_select;
    logic                cold;
    logic                bor_seen;
    seq_state_t          state;
    seq_state_t          next_state;
    logic                timer_load;
    logic                timer_done;
    logic [31:0]         stage_len;
    logic [31:0]         ext_len;
    logic                xtal_mode;
    logic                lock_needed;
    logic [31:0]         mon_cnt;
    logic [ADDR_W-1:0]   aw_addr_q;
    logic [31:0]         w_data_q;
    logic [3:0]          w_strb_q;
    logic                aw_held;
    logic                w_held;
    logic                wr_en;
    logic                reset_control_register_we;
    logic [31:0]         rd_mux;
    logic                rd_hit;
    logic                wr_hit;

    // three-stage synchronisers; change taken once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            filt  <= '0;
            filt_prev <= '0;
        end else begin
            sync1 <= {osc_clock, osc_ready, supply_stable, illegal_condition_reset, trap_conflict_reset,
                      config_mismatch_reset, watchdog_timeout_reset, external_pin_reset,
                      brown_out_reset, power_on_reset};
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= (filt & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
            filt_prev <= filt;
        end
    end

    // source onsets, one per status flag
    assign ev = {filt[6:3], instruction_reset, filt[2:0]} & ~{filt_prev[6:3], 1'b0, filt_prev[2:0]};
    assign src_any = (|filt[6:0]) | instruction_reset;
    assign osc_edge = filt[9] & ~filt_prev[9];

    // status flags: hardware set wins over software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_control_register <= FLAGS_RST;
        end else if (ev[FLAG_POR]) begin
            reset_control_register <= FLAGS_RST | ev;
        end else if (reset_control_register_we) begin
            reset_control_register <= w_data_q[NUM_FLAGS-1:0] | ev;
        end else begin
            reset_control_register <= reset_control_register | ev;
        end
    end

    // cold classification, cleared once released
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cold     <= 1'b1;
            bor_seen <= 1'b0;
        end else if (ev[FLAG_POR] || ev[FLAG_BOR]) begin
            cold     <= 1'b1;
            bor_seen <= ev[FLAG_BOR] | bor_seen;
        end else if (state == ST_RUN) begin
            cold     <= 1'b0;
            bor_seen <= 1'b0;
        end
    end

    // clock source chosen as the sequence leaves hold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_source <= BOOT_SEL_RST;
            pll_enable   <= 1'b0;
        end else if (state == ST_HOLD && next_state == ST_EXTEND && cold) begin
            clock_source <= boot_clock_select;
            pll_enable   <= boot_pll;
        end
    end

    // mode decode for the oscillator stages
    always_comb begin
        xtal_mode   = 1'b0;
        lock_needed = 1'b0;
        unique case (clock_source)
            CLK_CRYSTAL, CLK_HIGH_SPEED: begin
                xtal_mode   = 1'b1;
                lock_needed = pll_enable;
            end
            CLK_SECONDARY: xtal_mode = 1'b1;
            CLK_FAST_RC, CLK_EXTERNAL: lock_needed = pll_enable;
            default: ;
        endcase
    end

    // cold extension plus programmable power-up delay
    always_comb begin
        ext_len = '0;
        if (cold) begin
            ext_len = bor_seen ? 32'(BOR_EXT_CYC) : 32'(POR_EXT_CYC);
            if (power_up_delay_select != 3'h0) begin
                ext_len = ext_len + (32'(PWRT_UNIT_CYCLES) << power_up_delay_select);
            end
        end
    end

    // length loaded into the timer for the current stage
    always_comb begin
        stage_len = '0;
        unique case (state)
            ST_EXTEND: stage_len = ext_len;
            ST_OSC_DELAY: begin
                if (clock_source == CLK_FAST_RC) stage_len = 32'(FRC_OSCD_CYC);
                else if (clock_source == CLK_LOW_POWER_RC) stage_len = 32'(LOW_POWER_RC_OSCILLATOR_OSCD_CYC);
                else if (xtal_mode) stage_len = 32'(XTAL_OSCD_CYCLES);
            end
            ST_OST: stage_len = xtal_mode ? 32'(OST_EDGES) : '0;
            ST_LOCK: stage_len = lock_needed ? 32'(LOCK_CYCLES) : '0;
            default: stage_len = '0;
        endcase
    end

    // release sequence; any active source restarts it
    always_comb begin
        next_state = state;
        if (src_any) begin
            next_state = ST_HOLD;
        end else begin
            unique case (state)
                ST_HOLD:      next_state = ST_EXTEND;
                ST_EXTEND:    if (!timer_load && timer_done) next_state = ST_SUPPLY;
                ST_SUPPLY:    if (filt[7]) next_state = ST_OSC_DELAY;
                ST_OSC_DELAY: if (!timer_load && timer_done) next_state = ST_OST;
                ST_OST:       if (!timer_load && timer_done) next_state = ST_LOCK;
                ST_LOCK:      if (!timer_load && timer_done) next_state = ST_READY;
                ST_READY:     if (filt[8] && filt[7]) next_state = ST_RUN;
                ST_RUN:       next_state = ST_RUN;
                default:      next_state = ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state               <= ST_HOLD;
            timer_load          <= 1'b0;
            master_system_reset <= 1'b1;
        end else begin
            state               <= next_state;
            timer_load          <= (next_state != state);
            master_system_reset <= (next_state != ST_RUN);
        end
    end

    delay_timer #(
        .W (32)
    ) u_stage_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .load      (timer_load),
        .length    (stage_len),
        .tick      ((state != ST_OST) || osc_edge),
        .expired   (timer_done),
        .remaining ()
    );

    // fail-safe clock monitor: no oscillator edge for too long while running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_cnt    <= '0;
            clock_fail <= 1'b0;
        end else begin
            mon_cnt <= (osc_edge || state != ST_RUN) ? '0 : mon_cnt + 32'(1);
            if (state == ST_RUN && !osc_edge && mon_cnt == 32'(FSCM_CYCLES - 1)) begin
                clock_fail <= 1'b1;
            end else if (wr_en && wr_hit && aw_addr_q == OSC_CTRL_OFS && w_strb_q[0] && w_data_q[CLK_FAIL_BIT]) begin
                clock_fail <= 1'b0;
            end
        end
    end

    // configuration words survive the system reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_clock_select     <= BOOT_SEL_RST;
            boot_pll              <= 1'b0;
            power_up_delay_select <= PWRT_SEL_RST;
        end else if (wr_en && w_strb_q[0]) begin
            if (aw_addr_q == OSC_CONFIG_OFS) begin
                boot_clock_select <= w_data_q[2:0];
                boot_pll          <= w_data_q[PLL_EN_BIT];
            end
            if (aw_addr_q == POR_CONFIG_OFS) power_up_delay_select <= w_data_q[2:0];
        end
    end

    // axi4-lite write path
    assign wr_en   = aw_held && w_held && !bvalid;
    assign wr_hit  = (aw_addr_q == RESET_CTRL_OFS) || (aw_addr_q == OSC_CTRL_OFS) ||
                     (aw_addr_q == OSC_CONFIG_OFS) || (aw_addr_q == POR_CONFIG_OFS) ||
                     (aw_addr_q == SEQ_STATUS_OFS);
    assign reset_control_register_we = wr_en && aw_addr_q == RESET_CTRL_OFS && w_strb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held   <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                wready   <= 1'b0;
            end
            if (wr_en) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // axi4-lite read path
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = '0;
        unique case (araddr)
            RESET_CTRL_OFS: rd_mux[NUM_FLAGS-1:0] = reset_control_register;
            OSC_CTRL_OFS: begin
                rd_mux[CUR_CLK_LSB +: 3] = clock_source;
                rd_mux[CLK_FAIL_BIT]     = clock_fail;
            end
            OSC_CONFIG_OFS: rd_mux[PLL_EN_BIT:0] = {boot_pll, boot_clock_select};
            POR_CONFIG_OFS: rd_mux[2:0] = power_up_delay_select;
            SEQ_STATUS_OFS: rd_mux[STAT_COLD_BIT:0] = {cold, master_system_reset, state};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_mux;
            rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // helper counters for timing checks
    logic [31:0] stage_cnt;
    logic [31:0] ost_cnt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_cnt <= '0;
            ost_cnt   <= '0;
        end else begin
            stage_cnt <= (next_state != state) ? '0 : stage_cnt + 32'(1);
            ost_cnt   <= (state != ST_OST) ? '0 :
                         ost_cnt + 32'(osc_edge && !timer_load && !timer_done);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    src_holds_reset_a: assert property (src_any |=> master_system_reset)
        else $error("master reset not asserted after active source");
    por_clears_flags_a: assert property (ev[FLAG_POR] |=> reset_control_register == FLAGS_RST)
        else $error("power-on did not leave only the power-on flag");
    wdt_sets_flag_a: assert property (ev[FLAG_WDT] |=> reset_control_register[FLAG_WDT])
        else $error("watchdog flag not set");
    sw_set_quiet_a: assert property ((state == ST_RUN && reset_control_register_we && !src_any) |=> !master_system_reset)
        else $error("software flag write caused a reset");
    cold_clock_a: assert property ((state == ST_HOLD && next_state == ST_EXTEND && cold)
        |=> clock_source == $past(boot_clock_select))
        else $error("cold reset did not load boot clock");
    warm_clock_a: assert property ((state == ST_HOLD && next_state == ST_EXTEND && !cold)
        |=> $stable(clock_source))
        else $error("warm reset changed clock source");
    release_ready_a: assert property ($fell(master_system_reset) |-> $past(filt[8]) && $past(filt[7]))
        else $error("released without supply and oscillator ready");
    extend_time_a: assert property ((state == ST_EXTEND && next_state == ST_SUPPLY)
        |-> stage_cnt == ext_len + 32'(1))
        else $error("extension stage length wrong");
    osc_delay_a: assert property ((state == ST_OSC_DELAY && next_state == ST_OST)
        |-> stage_cnt == stage_len + 32'(1))
        else $error("oscillator delay length wrong");
    ost_edges_a: assert property ((state == ST_OST && next_state == ST_LOCK && xtal_mode)
        |-> ost_cnt == 32'(OST_EDGES))
        else $error("start-up timer edge count wrong");
    lock_wait_a: assert property ((state == ST_LOCK && next_state == ST_READY)
        |-> stage_cnt == (lock_needed ? 32'(LOCK_CYCLES + 1) : 32'(1)))
        else $error("pll lock wait wrong");
    brownout_restart_a: assert property (($fell(filt[FLAG_BOR]) && !src_any)
        |-> state == ST_HOLD ##1 (state == ST_EXTEND && bor_seen))
        else $error("brown-out did not restart the sequence");
    clock_fail_a: assert property ((state == ST_RUN && !osc_edge && mon_cnt == 32'(FSCM_CYCLES - 1))
        |=> clock_fail)
        else $error("clock failure not declared");

    cold_release_c: cover property (cold && $fell(master_system_reset));
    warm_release_c: cover property (!cold && $fell(master_system_reset));
    ost_done_c: cover property (state == ST_OST && next_state == ST_LOCK && xtal_mode);
    clock_fail_c: cover property ($rose(clock_fail));

endmodule

// File: test/osc_source_model.sv
/*
 supply supervisor and oscillator model facing the reset combiner.
 assumes aclk at 20 mhz; osc_clock runs at aclk/8.
*/
module osc_source_model (
    // clock
    input  wire logic aclk,
    // oscillator stop request from the bench
    input  wire logic osc_halt,
    // supply and oscillator status
    output logic      osc_clock,
    output logic      supply_stable,
    output logic      osc_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div = 3'h0;
    // supply settles only some time after power-up
    initial begin
        supply_stable = 1'b0;
        osc_ready = 1'b0;
        repeat (1000) @(posedge aclk);
        supply_stable <= 1'b1;
        osc_ready <= 1'b1;
    end
    always @(posedge aclk) div <= div + 3'h1;
    assign osc_clock = div[2] & ~osc_halt;
endmodule

// File: test/testbench.sv
/*
 self-checking bench of the reset source combiner.
 assumes the partner model for supplies and oscillator.
*/
module testbench;
    import reset_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, osc_clock, supply_stable, osc_ready, master_system_reset;
    logic awready, wready, bvalid, arready, rvalid, pll_enable, clock_fail;
    logic [7:0] src = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic [3:0] boot_cfg = 4'h0;
    logic osc_halt = 1'b0;
    logic [2:0] clock_source;
    logic [1:0] bresp, rresp, rr;
    int err_count = 0, total_checks = 0, cyc = 0, ost_min = 0;
    initial forever #25 aclk = ~aclk;
    osc_source_model osc_source_model_i (.*);
    reset_source_combiner #(.LOCK_CYCLES(20), .FSCM_CYCLES(50), .PWRT_UNIT_CYCLES(10), .XTAL_OSCD_CYCLES(5))
        reset_source_combiner_i (.*, .power_on_reset(src[0]), .brown_out_reset(src[1]),
        .external_pin_reset(src[2]), .instruction_reset(src[3]), .watchdog_timeout_reset(src[4]),
        .config_mismatch_reset(src[5]), .trap_conflict_reset(src[6]), .illegal_condition_reset(src[7]));
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rr = rresp;
    endtask
    // one reset source, then flags, release time and clock choice
    task automatic fire(input int b);
        int n = 0;
        wr(RESET_CTRL_OFS, b == 0 ? 32'hfe : 32'h0);
        src[b] <= 1'b1;
        repeat (b == FLAG_INSTR ? 1 : 8) @(posedge aclk);
        src[b] <= 1'b0;
        repeat (2) @(posedge aclk);
        check("master reset", 32'(master_system_reset), 32'h1);
        while (master_system_reset !== 1'b0) begin
            @(posedge aclk);
            n++;
        end
        check("extension", 32'(n >= (b == 1 ? 2000 : b == 0 ? 600 + ost_min : 0)), 32'h1);
        rd_reg(RESET_CTRL_OFS);
        check("flags", rd, 32'h1 << b);
        check("clock source", 32'(clock_source), 32'(b < 2 ? boot_cfg[2:0] : 3'(CLK_FAST_RC)));
        check("pll", 32'(pll_enable), 32'(b < 2 && boot_cfg[3]));
    endtask
    // oscillator stops while running, flag sticks until written clear
    task automatic clock_loss();
        check("clock ok", 32'(clock_fail), 32'h0);
        osc_halt <= 1'b1;
        repeat (30) @(posedge aclk);
        check("clock fail early", 32'(clock_fail), 32'h0);
        repeat (40) @(posedge aclk);
        check("clock fail", 32'(clock_fail), 32'h1);
        osc_halt <= 1'b0;
        repeat (10) @(posedge aclk);
        check("clock fail sticky", 32'(clock_fail), 32'h1);
        wr(OSC_CTRL_OFS, 32'h1);
        check("clock fail clear", 32'(clock_fail), 32'h0);
    endtask
    // cold boot into crystal with pll: start-up timer and lock wait
    task automatic crystal_boot();
        boot_cfg = {1'b1, CLK_CRYSTAL};
        ost_min = OST_EDGES * 8;
        wr(OSC_CONFIG_OFS, 32'(boot_cfg));
        fire(FLAG_POR);
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (800) @(posedge aclk);
        check("held for supply", 32'(master_system_reset), 32'h1);
        rd_reg(SEQ_STATUS_OFS);
        check("supply wait", rd, {26'h0, 1'b1, 1'b1, ST_SUPPLY});
        @(posedge aclk iff master_system_reset === 1'b0);
        rd_reg(RESET_CTRL_OFS);
        check("power-up flags", rd, 32'h1);
        wr(RESET_CTRL_OFS, 32'hfe);
        repeat (10) @(posedge aclk);
        check("no reset on set", 32'(master_system_reset), 32'h0);
        rd_reg(RESET_CTRL_OFS);
        check("flags set", rd, 32'hfe);
        rd_reg(8'h20);
        check("unmapped data", rd, 32'h0);
        check("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
        clock_loss();
        boot_cfg = {1'b0, CLK_LOW_POWER_RC};
        wr(OSC_CONFIG_OFS, 32'(boot_cfg));
        for (int i = 0; i < 8; i++) fire((i + 2) % 8);
        crystal_boot();
        stop_test();
    end
endmodule
